// ### spm_defines.svh
// Purpose: Offsets, reset values and timing counts of the serial port master.
// Assumes: Byte addresses on a 32-bit Avalon-MM slave, one register per word.
// Notes:   Included by bare name; definitions only.
`ifndef SPM_DEFINES_SVH
`define SPM_DEFINES_SVH

////////////////////////////////////////////////////////////////////////////////
// Register byte offsets.
`define SPM_OFF_CTRL   4'h0
`define SPM_OFF_STAT   4'h4
`define SPM_OFF_DATA   4'h8

////////////////////////////////////////////////////////////////////////////////
// Reset values.
`define SPM_CTRL_RESET 8'h00
`define SPM_DATA_RESET 8'h00

////////////////////////////////////////////////////////////////////////////////
// Half serial clock period in system clocks for each rate select code.
// The full divisors are 2, 4, 16 and 32.
`define SPM_HALF_R0    5'h01
`define SPM_HALF_R1    5'h02
`define SPM_HALF_R2    5'h08
`define SPM_HALF_R3    5'h10

// Index of the last serial clock edge in one byte; sixteen edges, two for each of the eight pulses.
`define SPM_LAST_EDGE  4'hf

`endif

// ### spm_pkg.sv
// Purpose: Types shared by the serial port master files.
// Assumes: Nothing beyond plain SystemVerilog.
// Notes:   Field layouts of the control and status registers live here.
package spm_pkg;

  // Control register layout.
  typedef struct packed {
    logic transfer_irq_enable;
    logic port_enable;
    logic unused5;
    logic master_select;
    logic clock_idle_level;
    logic clock_capture_phase;
    logic rate_select_hi;
    logic rate_select_lo;
  } spm_ctrl_t;

  // Status register layout.
  typedef struct packed {
    logic       transfer_done_flag;
    logic       write_collision_flag;
    logic       unused5;
    logic       mode_fault_flag;
    logic [2:0] unused3;
    logic       busy;
  } spm_stat_t;

  // Transfer engine states.
  typedef enum logic [1:0] {
    SPM_IDLE = 2'b01,
    SPM_RUN  = 2'b10
  } spm_state_t;

endpackage

// ### spm_sync.sv
// Purpose: Two flip-flop synchroniser for pins from outside the clock domain.
// Assumes: Inputs are levels that change slower than the clock.
// Notes:   Only the second stage is visible outside.
`timescale 1ns/1ns

module spm_sync #(
  parameter int W = 1
) (
  // Clock and reset.
  input  wire logic         clk_in,
  input  wire logic         nrst_in,
  // Data.
  input  wire logic [W-1:0] d_in,
  input  wire logic [W-1:0] init_in,
  output logic      [W-1:0] q_out
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta_reg <= '0;
      q_out    <= '0;
    end else begin
      meta_reg <= d_in;
      q_out    <= meta_reg;
    end
  end

  // The init port is kept for a uniform interface and holds no reset role.
  logic unused_init;
  assign unused_init = ^init_in;

endmodule

// ### spm_rate.sv
// Purpose: Divides the system clock into half serial clock period ticks.
// Assumes: Run is low between transfers so each byte starts a fresh period.
// Notes:   Tick is a one-cycle enable pulse.
`timescale 1ns/1ns
`include "spm_defines.svh"

module spm_rate (
  // Clock and reset.
  input  wire logic       clk_in,
  input  wire logic       nrst_in,
  // Control.
  input  wire logic       run_in,
  input  wire logic [1:0] sel_in,
  // Enable pulse.
  output logic            tick_out
);

  logic [4:0] cnt_reg;
  logic [4:0] half;

  always_comb begin
    case (sel_in)
      2'h0:    half = `SPM_HALF_R0;
      2'h1:    half = `SPM_HALF_R1;
      2'h2:    half = `SPM_HALF_R2;
      default: half = `SPM_HALF_R3;
    endcase
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_reg  <= 5'h00;
      tick_out <= 1'b0;
    end else if (!run_in) begin
      cnt_reg  <= 5'h00;
      tick_out <= 1'b0;
    end else if (cnt_reg >= half - 5'h01) begin
      cnt_reg  <= 5'h00;
      tick_out <= 1'b1;
    end else begin
      cnt_reg  <= cnt_reg + 5'h01;
      tick_out <= 1'b0;
    end
  end

endmodule

// ### spm_master.sv
// Purpose: Serial peripheral port in master configuration behind Avalon-MM.
// Assumes: Slave select and master-in are asynchronous pins; mask bit is local.
// Notes:   Each access holds waitrequest high for one cycle before answering.
`timescale 1ns/1ns
`include "spm_defines.svh"

// Summary of operation
// - Bytes move both ways at once, most significant bit first.
// - As master the port makes the serial clock and drives it out.
// - Two rate bits select one of four serial clock rates.
// - Both ends must use the same polarity and phase setting.
// - Select must stay high; master and enable bits hold only then.
// - Master drives master-out and samples master-in.
// - Writing the data register as master starts a transfer.
// - Written byte loads the shift register and leaves most significant first.
// - Completion sets the transfer done flag.
// - Interrupt requested when enabled and the CPU mask bit is clear.
// - Received byte copied to a buffer at completion; data reads return it.
// - Done flag clears after status access while set, then a data read.
// - Data writes ignored while done flag set until status is read.
// - Received bits replace sent bits; one flag marks completion.
// - Polarity sets clock idle level; phase picks the capture edge.
// - Each byte uses exactly eight serial clock pulses.
// - Select low as master sets mode fault, drops enable and master bits.
// - Data write during a transfer is dropped and sets write collision.
module spm_master (
  // Clock and reset.
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  // Avalon-MM slave.
  input  wire logic [3:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  // CPU interrupt mask bit and interrupt request.
  input  wire logic        cpu_irq_mask_in,
  output logic             irq_out,
  // Serial pins.
  input  wire logic        ss_n_in,
  input  wire logic        miso_in,
  output logic             sck_out,
  output logic             sck_oe_out,
  output logic             mosi_out,
  output logic             mosi_oe_out
);

  //////////////////////////////////////////////////////////////////////////////
  // State.
  spm_pkg::spm_ctrl_t  ctrl_reg;
  spm_pkg::spm_stat_t  stat;
  spm_pkg::spm_state_t state_reg;
  logic        done_reg;
  logic        done_arm_reg;
  logic        write_collision_flag_reg;
  logic        write_collision_flag_arm_reg;
  logic        mode_fault_flag_reg;
  logic        mode_fault_flag_arm_reg;
  logic [7:0]  sh_reg;
  logic [7:0]  sh_next;
  logic [7:0]  rxbuf_reg;
  logic [3:0]  edge_reg;
  logic        tick;
  logic        ss_n_s;
  logic        miso_s;
  logic [1:0]  pins_s;

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and rate divider.
  spm_sync #(.W(2)) u_sync (
    .clk_in  (clk_in),
    .nrst_in (nrst_in),
    .d_in    ({ss_n_in, miso_in}),
    .init_in (2'h0),
    .q_out   (pins_s)
  );
  assign ss_n_s = pins_s[1];
  assign miso_s = pins_s[0];

  spm_rate u_rate (
    .clk_in   (clk_in),
    .nrst_in  (nrst_in),
    .run_in   (state_reg == spm_pkg::SPM_RUN),
    .sel_in   ({ctrl_reg.rate_select_hi, ctrl_reg.rate_select_lo}),
    .tick_out (tick)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Bus slave: one wait cycle, then the access commits.
  function automatic logic hit(input logic [3:0] addr, input logic [3:0] off);
    hit = (addr[3:2] == off[3:2]);
  endfunction

  logic req;
  logic commit;
  logic acc_stat;
  logic wr_ctrl;
  logic wr_data;
  logic rd_data;
  assign req      = avs_read_in | avs_write_in;
  assign commit   = req & ~avs_waitrequest_out;
  assign acc_stat = commit & hit(avs_address_in, `SPM_OFF_STAT);
  assign wr_ctrl  = commit & avs_write_in & hit(avs_address_in, `SPM_OFF_CTRL);
  assign wr_data  = commit & avs_write_in & hit(avs_address_in, `SPM_OFF_DATA);
  assign rd_data  = commit & avs_read_in & hit(avs_address_in, `SPM_OFF_DATA);

  always_comb begin
    stat                      = '0;
    stat.transfer_done_flag   = done_reg;
    stat.write_collision_flag = write_collision_flag_reg;
    stat.mode_fault_flag      = mode_fault_flag_reg;
    stat.busy                 = (state_reg == spm_pkg::SPM_RUN);
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      avs_waitrequest_out <= 1'b1;
    end else begin
      avs_waitrequest_out <= ~(req & avs_waitrequest_out);
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      avs_readdata_out <= 32'h0000_0000;
    end else if (avs_read_in && avs_waitrequest_out) begin
      if (hit(avs_address_in, `SPM_OFF_CTRL)) begin
        avs_readdata_out <= {24'h00_0000, ctrl_reg};
      end else if (hit(avs_address_in, `SPM_OFF_STAT)) begin
        avs_readdata_out <= {24'h00_0000, stat};
      end else if (hit(avs_address_in, `SPM_OFF_DATA)) begin
        avs_readdata_out <= {24'h00_0000, rxbuf_reg};
      end else begin
        avs_readdata_out <= 32'h0000_0000;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Events.
  logic fault;
  logic wr_ok;
  logic start;
  logic sample;
  logic complete;
  assign fault    = ctrl_reg.master_select & ctrl_reg.port_enable & ~ss_n_s;
  assign wr_ok    = wr_data & ~(done_reg & ~done_arm_reg);
  assign start    = wr_ok & (state_reg == spm_pkg::SPM_IDLE) & ctrl_reg.master_select
                    & ctrl_reg.port_enable & ~fault;
  assign sample   = (edge_reg[0] == ctrl_reg.clock_capture_phase);
  assign complete = (state_reg == spm_pkg::SPM_RUN) & tick & ~fault
                    & (edge_reg == `SPM_LAST_EDGE);

  always_comb begin
    sh_next = sample ? {sh_reg[6:0], miso_s} : sh_reg;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Control register.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ctrl_reg <= `SPM_CTRL_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= avs_writedata_in[7:0];
        if (mode_fault_flag_reg && !mode_fault_flag_arm_reg) begin
          ctrl_reg.port_enable   <= 1'b0;
          ctrl_reg.master_select <= 1'b0;
        end
      end
      if (fault) begin
        ctrl_reg.port_enable   <= 1'b0;
        ctrl_reg.master_select <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Status flags; a setting event always wins over a clear.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      done_reg     <= 1'b0;
      done_arm_reg <= 1'b0;
    end else if (complete) begin
      done_reg     <= 1'b1;
      done_arm_reg <= 1'b0;
    end else if (rd_data && done_arm_reg) begin
      done_reg     <= 1'b0;
      done_arm_reg <= 1'b0;
    end else if (acc_stat && done_reg) begin
      done_arm_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      write_collision_flag_reg     <= 1'b0;
      write_collision_flag_arm_reg <= 1'b0;
    end else if (wr_ok && state_reg == spm_pkg::SPM_RUN) begin
      write_collision_flag_reg     <= 1'b1;
      write_collision_flag_arm_reg <= 1'b0;
    end else if ((rd_data || wr_data) && write_collision_flag_arm_reg) begin
      write_collision_flag_reg     <= 1'b0;
      write_collision_flag_arm_reg <= 1'b0;
    end else if (acc_stat && write_collision_flag_reg) begin
      write_collision_flag_arm_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mode_fault_flag_reg     <= 1'b0;
      mode_fault_flag_arm_reg <= 1'b0;
    end else if (fault) begin
      mode_fault_flag_reg     <= 1'b1;
      mode_fault_flag_arm_reg <= 1'b0;
    end else if (wr_ctrl && mode_fault_flag_arm_reg) begin
      mode_fault_flag_reg     <= 1'b0;
      mode_fault_flag_arm_reg <= 1'b0;
    end else if (acc_stat && mode_fault_flag_reg) begin
      mode_fault_flag_arm_reg <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Transfer engine.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_reg <= spm_pkg::SPM_IDLE;
      edge_reg  <= 4'h0;
      sh_reg    <= `SPM_DATA_RESET;
      sck_out   <= 1'b0;
      mosi_out  <= 1'b0;
      rxbuf_reg <= `SPM_DATA_RESET;
    end else begin
      case (state_reg)
        spm_pkg::SPM_IDLE: begin
          sck_out  <= ctrl_reg.clock_idle_level;
          edge_reg <= 4'h0;
          if (wr_ok) begin
            sh_reg <= avs_writedata_in[7:0];
          end
          if (start) begin
            state_reg <= spm_pkg::SPM_RUN;
            mosi_out  <= avs_writedata_in[7];
          end
        end
        spm_pkg::SPM_RUN: begin
          if (fault) begin
            state_reg <= spm_pkg::SPM_IDLE;
          end else if (tick) begin
            sck_out  <= ~sck_out;
            edge_reg <= edge_reg + 4'h1;
            sh_reg   <= sh_next;
            if (!sample) begin
              mosi_out <= sh_reg[7];
            end
            if (complete) begin
              rxbuf_reg <= sh_next;
              state_reg <= spm_pkg::SPM_IDLE;
            end
          end
        end
        default: begin
          state_reg <= spm_pkg::SPM_IDLE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin enables and interrupt.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sck_oe_out  <= 1'b0;
      mosi_oe_out <= 1'b0;
    end else begin
      sck_oe_out  <= ctrl_reg.port_enable & ctrl_reg.master_select & ~fault;
      mosi_oe_out <= ctrl_reg.port_enable & ctrl_reg.master_select & ~fault;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= ctrl_reg.transfer_irq_enable & (done_reg | mode_fault_flag_reg) & ~cpu_irq_mask_in;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks.
  logic [4:0] tog_reg;
  logic       sck_q_reg;
  logic       run_q_reg;
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tog_reg   <= 5'h00;
      sck_q_reg <= 1'b0;
      run_q_reg <= 1'b0;
    end else begin
      sck_q_reg <= sck_out;
      run_q_reg <= stat.busy;
      if (start) begin
        tog_reg <= 5'h00;
      end else if ((stat.busy || run_q_reg) && sck_out != sck_q_reg) begin
        tog_reg <= tog_reg + 5'h01;
      end
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);

  a_eight_pulses: assert property ($past(complete, 2) |-> tog_reg == 5'h10)
    else $error("byte did not use eight clock pulses");
  a_done_sets: assert property (complete |=> done_reg)
    else $error("done flag not set at completion");
  a_buffer_copy: assert property (complete |=> rxbuf_reg == $past(sh_next))
    else $error("received byte not buffered");
  a_write_starts: assert property (start |=> state_reg == spm_pkg::SPM_RUN && mosi_out == $past(avs_writedata_in[7]))
    else $error("data write did not start transfer msb first");
  a_collision_flag: assert property (wr_ok && stat.busy && !tick && !fault
    |=> write_collision_flag_reg && stat.busy && $stable(sh_reg))
    else $error("collision not flagged or transfer disturbed");
  a_mode_fault: assert property (fault |=> mode_fault_flag_reg && !ctrl_reg.port_enable && !ctrl_reg.master_select ##1 !sck_oe_out)
    else $error("mode fault handling wrong");
  a_done_holds: assert property (done_reg && !(rd_data && done_arm_reg) |=> done_reg)
    else $error("done flag cleared without sequence");
  a_write_inhibit: assert property (wr_data && done_reg && !done_arm_reg |=> $stable(sh_reg) && state_reg == spm_pkg::SPM_IDLE)
    else $error("inhibited write took effect");
  a_irq_gate: assert property (irq_out == $past(ctrl_reg.transfer_irq_enable && (done_reg || mode_fault_flag_reg) && !cpu_irq_mask_in))
    else $error("interrupt request mismatch");
  a_idle_level: assert property (state_reg == spm_pkg::SPM_IDLE && $past(state_reg == spm_pkg::SPM_IDLE) && $stable(ctrl_reg) |-> sck_out == ctrl_reg.clock_idle_level)
    else $error("clock not at idle level");
  a_bus_answer: assert property (req && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("bus access not answered");

  c_transfer: cover property (complete);
  c_phase_one: cover property (complete && ctrl_reg.clock_capture_phase);
  c_fault: cover property (fault);
  c_collision: cover property (wr_ok && state_reg == spm_pkg::SPM_RUN);

endmodule

// ### spm_slave_model.sv
// Purpose: Behavioural serial slave on the far side of the port master.
// Assumes: Its own select comes from the bench, apart from the master's ss_n.
// Notes:   A released data line shows the inverse of its last bit.
`timescale 1ns/1ns

module spm_slave_model (
  // Setup.
  input  wire logic       sel_n_in,
  input  wire logic       idle_in,
  input  wire logic       phase_in,
  input  wire logic [7:0] tx_in,
  // Serial pins.
  input  wire logic       sck_in,
  input  wire logic       mosi_in,
  output logic            miso_out,
  // Received byte.
  output logic      [7:0] rx_out
);
  int idx;

  initial begin
    miso_out = 1'b0;
    rx_out   = 8'h00;
    idx      = 7;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // load on select.
  always @(negedge sel_n_in) begin
    idx = phase_in ? 7 : 6;
    miso_out = phase_in ? ~miso_out : tx_in[7];
  end

  always @(posedge sel_n_in) begin
    miso_out = ~miso_out;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // shift both ways.
  always @(sck_in) begin
    if (sel_n_in === 1'b0) begin
      if ((sck_in != idle_in) != phase_in) begin
        rx_out = {rx_out[6:0], mosi_in};
      end else if (idx >= 0) begin
        miso_out = tx_in[idx];
        idx = idx - 1;
      end else begin
        miso_out = ~miso_out;
      end
    end
  end
endmodule

// ### spm_master_test.sv
// Purpose: Self-checking bench of the serial port master.
// Assumes: Rates 2 and 3 for received data; master-in passes two sync flops.
// Notes:   A monitor counts serial clock edges and checks their spacing.
`timescale 1ns/1ns
`include "spm_defines.svh"

module spm_master_test;
  // Bench signals.
  logic        clk_in, nrst_in, rd, wr, mask, ss_n, sel_n, pol, pha, armed, gap_on;
  logic [3:0]  addr;
  logic [31:0] wdata, rdata;
  logic        wreq, irq, miso, sck, sck_oe, mosi, mosi_oe, sck_q;
  logic [7:0]  s_tx, s_rx, rb;
  int          error_cnt, checked, cyc, last, edges, gap_exp, gap_bad;

  spm_master DUT (.clk_in(clk_in), .nrst_in(nrst_in), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wreq), .cpu_irq_mask_in(mask),
    .irq_out(irq), .ss_n_in(ss_n), .miso_in(miso), .sck_out(sck),
    .sck_oe_out(sck_oe), .mosi_out(mosi), .mosi_oe_out(mosi_oe));

  spm_slave_model slave (.sel_n_in(sel_n), .idle_in(pol), .phase_in(pha), .tx_in(s_tx),
    .sck_in(sck), .mosi_in(mosi), .miso_out(miso), .rx_out(s_rx));

  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Edge monitor and timeout.
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    sck_q <= sck;
    if (!armed) begin
      gap_on <= 1'b0;
    end else if (sck !== sck_q) begin
      edges <= edges + 1;
      last <= cyc;
      gap_on <= 1'b1;
      if (gap_on && cyc - last != gap_exp) gap_bad <= gap_bad + 1;
    end
    if (cyc == 20000) begin
      error_cnt++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= {24'h000000, d};
    rd <= !w;
    wr <= w;
    forever begin
      @(posedge clk_in);
      if (wreq === 1'b0) break;
    end
    rb = rdata[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic start(input logic [7:0] tx, input logic [7:0] d);
    sel_n <= 1'b1;
    s_tx <= tx;
    @(posedge clk_in);
    sel_n <= 1'b0;
    bus(1'b1, `SPM_OFF_DATA, d);
  endtask

  task automatic wait_edges(input int n);
    int k;
    k = 0;
    while (edges < n && k < 2000) begin
      @(posedge clk_in);
      k++;
    end
    repeat (4) @(posedge clk_in);
  endtask

  task automatic fin(input logic [7:0] x, input logic use_x, input logic wc);
    spm_pkg::spm_stat_t st;
    bus(1'b0, `SPM_OFF_STAT, 8'h00);
    st = spm_pkg::spm_stat_t'(rb);
    chk("done", st.transfer_done_flag, 1'b1);
    chk("write_collision_flag", st.write_collision_flag, wc);
    bus(1'b0, `SPM_OFF_DATA, 8'h00);
    if (use_x) chk("rx buffer", rb, x);
    bus(1'b0, `SPM_OFF_STAT, 8'h00);
    chk("flags clear", rb[7:6], 2'b00);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    bus(1'b0, `SPM_OFF_CTRL, 8'h00);
    chk("ctrl reset", rb, `SPM_CTRL_RESET);
    bus(1'b0, `SPM_OFF_DATA, 8'h00);
    chk("data reset", rb, `SPM_DATA_RESET);
    bus(1'b0, `SPM_OFF_STAT, 8'h00);
    chk("stat reset", rb, 8'h00);
    bus(1'b1, 4'hc, 8'hff);
    bus(1'b0, 4'hc, 8'h00);
    chk("unmapped", rb, 8'h00);
    bus(1'b0, `SPM_OFF_CTRL, 8'h00);
    chk("ctrl kept", rb, 8'h00);
    chk("oe reset", sck_oe, 1'b0);
    $display("test reset done");
  endtask

  task automatic t_xfer(input logic [1:0] r, input logic p, input logic h);
    int e0;
    int b0;
    logic [7:0] m;
    logic [7:0] s;
    m = {4'ha, p, h, r};
    s = {r, h, p, 4'h6};
    gap_exp = r[1] ? (r[0] ? `SPM_HALF_R3 : `SPM_HALF_R2) : (r[0] ? `SPM_HALF_R1 : `SPM_HALF_R0);
    pol <= p;
    pha <= h;
    bus(1'b1, `SPM_OFF_CTRL, {4'h5, p, h, r});
    repeat (3) @(posedge clk_in);
    armed <= 1'b1;
    e0 = edges;
    b0 = gap_bad;
    start(s, m);
    chk("sck oe", {sck_oe, mosi_oe}, 2'b11);
    wait_edges(e0 + 16);
    chk("edges", 8'(edges - e0), 8'h10);
    chk("gaps", 8'(gap_bad - b0), 8'h00);
    chk("idle", sck, p);
    chk("slave rx", s_rx, m);
    armed <= 1'b0;
    fin(s, r[1], 1'b0);
    $display("test transfer rate %0d mode %0d%0d done", r, p, h);
  endtask

  task automatic t_coll();
    int e0;
    gap_exp = `SPM_HALF_R3;
    pol <= 1'b0;
    pha <= 1'b0;
    bus(1'b1, `SPM_OFF_CTRL, 8'h53);
    repeat (3) @(posedge clk_in);
    armed <= 1'b1;
    e0 = edges;
    start(8'h81, 8'h3c);
    repeat (20) @(posedge clk_in);
    bus(1'b1, `SPM_OFF_DATA, 8'hff);
    wait_edges(e0 + 16);
    chk("edges", 8'(edges - e0), 8'h10);
    chk("slave rx", s_rx, 8'h3c);
    armed <= 1'b0;
    fin(8'h81, 1'b1, 1'b1);
    $display("test collision done");
  endtask

  task automatic t_inhibit();
    int e0;
    mask <= 1'b1;
    bus(1'b1, `SPM_OFF_CTRL, 8'hd2);
    e0 = edges;
    armed <= 1'b1;
    start(8'h42, 8'h5a);
    wait_edges(e0 + 16);
    chk("irq masked", irq, 1'b0);
    mask <= 1'b0;
    repeat (3) @(posedge clk_in);
    chk("irq", irq, 1'b1);
    e0 = edges;
    bus(1'b1, `SPM_OFF_DATA, 8'ha5);
    repeat (40) @(posedge clk_in);
    chk("inhibit", 8'(edges - e0), 8'h00);
    fin(8'h42, 1'b1, 1'b0);
    chk("irq clear", irq, 1'b0);
    e0 = edges;
    start(8'h99, 8'h5a);
    wait_edges(e0 + 16);
    chk("slave rx", s_rx, 8'h5a);
    armed <= 1'b0;
    fin(8'h99, 1'b1, 1'b0);
    $display("test inhibit done");
  endtask

  task automatic t_fault();
    bus(1'b1, `SPM_OFF_CTRL, 8'h52);
    ss_n <= 1'b0;
    repeat (8) @(posedge clk_in);
    chk("oe fault", {sck_oe, mosi_oe}, 2'b00);
    bus(1'b0, `SPM_OFF_STAT, 8'h00);
    chk("mode_fault_flag", rb[4], 1'b1);
    bus(1'b0, `SPM_OFF_CTRL, 8'h00);
    chk("ctrl fault", rb, 8'h02);
    ss_n <= 1'b1;
    repeat (4) @(posedge clk_in);
    bus(1'b1, `SPM_OFF_CTRL, 8'h52);
    bus(1'b0, `SPM_OFF_CTRL, 8'h00);
    chk("ctrl back", rb, 8'h52);
    bus(1'b0, `SPM_OFF_STAT, 8'h00);
    chk("mode_fault_flag clear", rb[4], 1'b0);
    start(8'h00, 8'h77);
    repeat (20) @(posedge clk_in);
    ss_n <= 1'b0;
    repeat (8) @(posedge clk_in);
    bus(1'b0, `SPM_OFF_STAT, 8'h00);
    chk("abort flags", {rb[7], rb[4], rb[0]}, 3'b010);
    chk("abort idle", sck, 1'b0);
    $display("test fault done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    nrst_in = 1'b0;
    {rd, wr, mask, pol, pha, armed, gap_on, sck_q} = 8'h00;
    {ss_n, sel_n} = 2'b11;
    addr = 4'h0;
    wdata = 32'h00000000;
    s_tx = 8'h00;
    {error_cnt, checked, cyc, last, edges, gap_exp, gap_bad} = '0;
    repeat (8) @(posedge clk_in);
    nrst_in <= 1'b1;
    t_reset();
    for (int r = 0; r < 4; r++) t_xfer(2'(r), 1'b0, 1'b0);
    t_xfer(2'h2, 1'b1, 1'b0);
    t_xfer(2'h2, 1'b0, 1'b1);
    t_xfer(2'h3, 1'b1, 1'b1);
    t_coll();
    t_inhibit();
    t_fault();
    complete_run();
  end
endmodule
